// [hw/flash_ctl_defs.vh]
// timing and register constants for the flash host controller
// assumes a 25 MHz system clock; all counts are derived from it
`ifndef FLASH_CTL_DEFS_VH
`define FLASH_CTL_DEFS_VH

`define CLK_MHZ 25
// ---- times in their own units ----
`define T_RESET_BUSY_US 20
`define T_RESET_IDLE_NS 500
`define T_RESET_PULSE_NS 500
`define T_RESET_HIGH_NS 200
`define T_STANDBY_US 20
`define T_POLL_HIGH_NS 20
`define T_UNPROT_SETUP_US 4
`define T_UNPROT_HOLD_US 4
`define T_BUSY_NS 90
`define T_WRITE_PULSE_NS 60
`define T_ACCESS_NS 100
// ---- cycle counts (least times round up, longest round down) ----
`define CYC_RESET_PULSE ((`T_RESET_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define CYC_RESET_BUSY (`T_RESET_BUSY_US * `CLK_MHZ)
`define CYC_RESET_HIGH ((`T_RESET_HIGH_NS * `CLK_MHZ + 999) / 1000)
`define CYC_POLL_HIGH ((`T_POLL_HIGH_NS * `CLK_MHZ + 999) / 1000)
`define CYC_UNPROT_SETUP (`T_UNPROT_SETUP_US * `CLK_MHZ)
`define CYC_UNPROT_HOLD (`T_UNPROT_HOLD_US * `CLK_MHZ)
`define CYC_BUSY_MAX ((`T_BUSY_NS * `CLK_MHZ) / 1000)
`define CYC_WRITE_PULSE ((`T_WRITE_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define CYC_ACCESS ((`T_ACCESS_NS * `CLK_MHZ + 999) / 1000)
// ---- register word offsets (byte address = 4 * index) ----
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STAT 4'h3
`define REG_RDATA 4'h4
// ---- control register fields ----
`define CMD_LSB 0
`define CMD_W 3
`define CTRL_BOOST_BIT 4
`define CTRL_ELEV_BIT 5
// ---- commands ----
`define CMD_READ 3'h1
`define CMD_WRITE 3'h2
`define CMD_POLL 3'h3
`define CMD_RESET 3'h4
`define CMD_PROTECT 3'h5
`define CMD_UNPROTECT 3'h6
// ---- protect address codes on bits six, one, zero ----
`define PROT_ADDR_CODE 3'h2
`define UNPROT_ADDR_CODE 3'h6
`define RESET_CTRL 6'h00

`endif

// [hw/flash_host_ctl.v]
// host controller that drives an asynchronous dual-bank nor flash over its pins
// assumes an avalon-mm master on the same 25 MHz clock; the flash has no clock
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
module flash_host_ctl (
   input wire i_clock,
   input wire i_rst_n,
   // avalon-mm slave, word addressed by index
   input wire [3:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   // flash pins
   output reg [20:0] o_fl_addr,
   input wire [15:0] i_fl_dq,
   output reg [15:0] o_fl_dq,
   output reg o_fl_dq_oe,
   output reg o_fl_ce_n,
   output reg o_fl_oe_n,
   output reg o_fl_we_n,
   output reg o_fl_reset_n,
   output reg o_fl_elevated,
   output reg o_fl_boost,
   input wire i_ready_busy_out
);
   // ==========================================================
   // state codes
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_RD = 4'h1;
   localparam [3:0] ST_WR = 4'h2;
   localparam [3:0] ST_WR_HI = 4'h3;
   localparam [3:0] ST_RST_LO = 4'h4;
   localparam [3:0] ST_RST_HI = 4'h5;
   localparam [3:0] ST_POLL_HI = 4'h6;
   localparam [3:0] ST_EL_SETUP = 4'h7;
   localparam [3:0] ST_EL_HOLD = 4'h8;

   // ==========================================================
   // registers
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [5:0] ctrl_r;
   reg [20:0] addr_r;
   reg [15:0] wdata_r;
   reg [15:0] rdata_r;
   reg [15:0] prev_r;
   reg toggled_r;
   reg suspend_tog_r;
   reg busy_r;
   reg [2:0] cmd_r;
   reg cmd_go_r;
   reg long_reset_r;
   reg load;
   reg [11:0] load_val;
   wire tmr_done;
   wire [15:0] dq_s;
   wire rb_s;

   // ==========================================================
   // input synchronisers
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_dq
         sync2 u_dq (
            .i_clock(i_clock),
            .i_rst_n(i_rst_n),
            .i_level(i_fl_dq[g]),
            .o_level(dq_s[g])
         );
      end
   endgenerate
   sync2 u_rb (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_level(i_ready_busy_out),
      .o_level(rb_s)
   );

   wait_timer u_tmr (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_load(load),
      .i_count(load_val),
      .o_done(tmr_done)
   );

   // ==========================================================
   // address with protect code forced onto bits six, one, zero
   function [20:0] prot_addr;
      input [20:0] a;
      input [2:0] code;
      begin
         prot_addr = {a[20:7], code[2], a[5:2], code[1], code[0]};
      end
   endfunction
   // timing counts all fit the 12-bit timer; the cut is deliberate
   function [11:0] cyc12;
      input integer c;
      cyc12 = c[11:0];
   endfunction

   // ==========================================================
   // bus slave: a request is held off while a command is in flight
   wire bus_busy = cmd_go_r || (state_r != ST_IDLE);
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         ctrl_r <= `RESET_CTRL;
         addr_r <= 21'h00_0000;
         wdata_r <= 16'h0000;
         cmd_r <= 3'h0;
         cmd_go_r <= 1'b0;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0000_0000;
      end else begin
         o_avs_waitrequest <= 1'b1;
         // one-cycle strobe; cmd 0 must fire too so that elevated mode can be left
         cmd_go_r <= 1'b0;
         if ((i_avs_write || i_avs_read) && o_avs_waitrequest && !bus_busy) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
            if (i_avs_write) begin
               case (i_avs_address)
                  `REG_CTRL: begin
                     ctrl_r <= i_avs_writedata[5:0];
                     cmd_r <= i_avs_writedata[`CMD_LSB +: `CMD_W];
                     cmd_go_r <= 1'b1;
                  end
                  `REG_ADDR: addr_r <= i_avs_writedata[20:0];
                  `REG_DATA: wdata_r <= i_avs_writedata[15:0];
                  default: ;
               endcase
            end else begin
               case (i_avs_address)
                  `REG_CTRL: o_avs_readdata <= {26'h000_0000, ctrl_r};
                  `REG_ADDR: o_avs_readdata <= {11'h000, addr_r};
                  `REG_DATA: o_avs_readdata <= {16'h0000, wdata_r};
                  `REG_STAT: o_avs_readdata <= {27'h000_0000, long_reset_r,
                     suspend_tog_r, toggled_r, busy_r, rb_s};
                  `REG_RDATA: o_avs_readdata <= {16'h0000, rdata_r};
                  default: o_avs_readdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // ==========================================================
   // sequencer
   always @* begin
      state_nxt = state_r;
      load = 1'b0;
      load_val = 12'h000;
      case (state_r)
         ST_IDLE: begin
            if (cmd_go_r) begin
               load = 1'b1;
               case (cmd_r)
                  `CMD_READ, `CMD_POLL: begin
                     load_val = cyc12(`CYC_ACCESS);
                     state_nxt = ST_RD;
                  end
                  `CMD_WRITE, `CMD_PROTECT, `CMD_UNPROTECT: begin
                     // elevated reset needs its setup time before writes
                     if (ctrl_r[`CTRL_ELEV_BIT] && !o_fl_elevated) begin
                        load_val = cyc12(`CYC_UNPROT_SETUP);
                        state_nxt = ST_EL_SETUP;
                     end else begin
                        load_val = cyc12(`CYC_WRITE_PULSE);
                        state_nxt = ST_WR;
                     end
                  end
                  `CMD_RESET: begin
                     load_val = cyc12(`CYC_RESET_BUSY);
                     state_nxt = ST_RST_LO;
                  end
                  default: begin
                     // leaving elevated mode waits for ready, then holds
                     if (o_fl_elevated && !ctrl_r[`CTRL_ELEV_BIT]) begin
                        load_val = cyc12(`CYC_UNPROT_HOLD);
                        state_nxt = ST_EL_HOLD;
                     end
                  end
               endcase
            end
         end
         ST_EL_SETUP: begin
            if (tmr_done) begin
               load = 1'b1;
               load_val = cyc12(`CYC_WRITE_PULSE);
               state_nxt = ST_WR;
            end
         end
         ST_EL_HOLD: begin
            if (!rb_s) begin
               load = 1'b1;
               load_val = cyc12(`CYC_UNPROT_HOLD);
            end else if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RD: begin
            if (tmr_done) begin
               load = 1'b1;
               load_val = cyc12(`CYC_POLL_HIGH);
               state_nxt = ST_POLL_HI;
            end
         end
         ST_POLL_HI: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WR: begin
            if (tmr_done) begin
               load = 1'b1;
               load_val = cyc12(`CYC_WRITE_PULSE);
               state_nxt = ST_WR_HI;
            end
         end
         ST_WR_HI: begin
            // a new write may follow as soon as the high time has run; ready is not waited for
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RST_LO: begin
            // held long enough for abort, pulse width and standby entry
            if (tmr_done) begin
               load = 1'b1;
               load_val = cyc12(`CYC_RESET_HIGH);
               state_nxt = ST_RST_HI;
            end
         end
         ST_RST_HI: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ==========================================================
   // pin drive and status capture
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_r <= ST_IDLE;
         o_fl_addr <= 21'h00_0000;
         o_fl_dq <= 16'h0000;
         o_fl_dq_oe <= 1'b0;
         o_fl_ce_n <= 1'b1;
         o_fl_oe_n <= 1'b1;
         o_fl_we_n <= 1'b1;
         o_fl_reset_n <= 1'b1;
         o_fl_elevated <= 1'b0;
         o_fl_boost <= 1'b0;
         rdata_r <= 16'h0000;
         prev_r <= 16'h0000;
         toggled_r <= 1'b0;
         suspend_tog_r <= 1'b0;
         busy_r <= 1'b0;
         long_reset_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         o_fl_boost <= ctrl_r[`CTRL_BOOST_BIT];
         busy_r <= !rb_s;
         case (state_nxt)
            ST_RD: begin
               o_fl_addr <= addr_r;
               o_fl_dq_oe <= 1'b0;
               o_fl_ce_n <= 1'b0;
               o_fl_oe_n <= 1'b0;
            end
            ST_WR: begin
               if (cmd_r == `CMD_PROTECT) begin
                  o_fl_addr <= prot_addr(addr_r, `PROT_ADDR_CODE);
               end else if (cmd_r == `CMD_UNPROTECT) begin
                  o_fl_addr <= prot_addr(addr_r, `UNPROT_ADDR_CODE);
               end else begin
                  o_fl_addr <= addr_r;
               end
               o_fl_dq <= wdata_r;
               o_fl_dq_oe <= 1'b1;
               o_fl_ce_n <= 1'b0;
               o_fl_we_n <= 1'b0;
            end
            ST_RST_LO: begin
               o_fl_reset_n <= 1'b0;
               long_reset_r <= 1'b1;
            end
            ST_EL_SETUP: o_fl_elevated <= 1'b1;
            ST_IDLE: begin
               if (state_r == ST_EL_HOLD) begin
                  o_fl_elevated <= 1'b0;
               end
            end
            default: begin
               // enables high: ends the access and separates status reads
               o_fl_ce_n <= 1'b1;
               o_fl_oe_n <= 1'b1;
               o_fl_we_n <= 1'b1;
               o_fl_dq_oe <= 1'b0;
               o_fl_reset_n <= 1'b1;
            end
         endcase
         // sample the bus at the end of the access time
         if (state_r == ST_RD && tmr_done) begin
            rdata_r <= dq_s;
            if (cmd_r == `CMD_POLL) begin
               toggled_r <= (dq_s[6] != prev_r[6]);
               suspend_tog_r <= (dq_s[2] != prev_r[2]);
               prev_r <= dq_s;
            end
         end
      end
   end
endmodule // flash_host_ctl
`default_nettype wire

// [hw/sync2.v]
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to i_clock
`timescale 1ns/1ps
`default_nettype none
module sync2 (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_level,
   output reg o_level
);
   reg meta_r;
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         meta_r <= 1'b0;
         o_level <= 1'b0;
      end else begin
         meta_r <= i_level;
         o_level <= meta_r;
      end
   end
endmodule // sync2
`default_nettype wire

// [hw/wait_timer.v]
// load-and-count-down timer; o_done is high while the count is zero
// assumes loads come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module wait_timer (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_load,
   input wire [11:0] i_count,
   output wire o_done
);
   reg [11:0] count_r;
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         count_r <= 12'h000;
      end else if (i_load) begin
         count_r <= i_count;
      end else if (count_r != 12'h000) begin
         count_r <= count_r - 12'h001;
      end
   end
   assign o_done = (count_r == 12'h000);
endmodule // wait_timer
`default_nettype wire

// [tb/flash_dev_model.sv]
// behavioural model of the nor flash as seen at its pins
// assumes zero-delay host pins; resolves the shared data lines too
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int PROG_NS = 11000,
   parameter int BOOST_NS = 5000,
   // bank select bit; where the bank boundary sits is a stand-in
   parameter int BANK_BIT = 20
) (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_reset_n,
   input wire logic i_boost,
   input wire logic [20:0] i_addr,
   input wire logic [15:0] i_dq_host,
   input wire logic i_dq_host_oe,
   output logic [15:0] o_dq_bus,
   output logic o_ready_busy_out
);
   // ==========================================================
   // array, programming and hardware reset
   logic [15:0] mem [int];
   logic [15:0] wd, dv, last;
   logic busy = 1'b0, armed = 1'b0, tog6 = 1'b0;
   int wa, job = 0;
   wire rd_on = !i_ce_n && !i_oe_n && i_reset_n;
   function automatic logic [15:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   task automatic done_after(input int j, input int t);
      #(t);
      if (j == job) busy = 1'b0;
   endtask
   // latch while both are low: the two strobes rise in the same step
   always @* if (!i_we_n && !i_ce_n && i_reset_n && !busy) begin
      wa = int'(i_addr);
      wd = i_dq_host;
      armed = 1'b1;
   end
   always @(posedge i_we_n or posedge i_ce_n) if (armed) begin
      armed = 1'b0;
      mem[wa] = rd(wa) & wd;
      busy = 1'b1;
      job++;
      fork done_after(job, i_boost ? BOOST_NS : PROG_NS); join_none
   end
   always @(negedge i_reset_n) begin
      if (busy) mem[wa] = 16'h0000;
      job++;
      busy = 1'b0;
   end
   // ==========================================================
   // status and data lines
   always @(posedge rd_on) if (busy) tog6 = ~tog6;
   // only the bank being programmed shows status; the other reads its array at once
   always @* dv = (busy && i_addr[BANK_BIT] == wa[BANK_BIT]) ?
      {9'h000, tog6, 6'h00} : rd(int'(i_addr));
   // a released bus shows the inverse of its last value, never a settled unknown
   always @* if (i_dq_host_oe) last = i_dq_host; else if (rd_on) last = dv;
   assign o_dq_bus = i_dq_host_oe ? i_dq_host : (rd_on ? dv : ~last);
   assign o_ready_busy_out = !busy;
endmodule // flash_dev_model
`default_nettype wire

// [tb/flash_host_ctl_sva.sv]
// port-level checker for the flash host controller
// assumes it is bound to flash_host_ctl and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
module flash_host_ctl_sva (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [20:0] o_fl_addr,
   input wire logic [15:0] i_fl_dq,
   input wire logic [15:0] o_fl_dq,
   input wire logic o_fl_dq_oe,
   input wire logic o_fl_ce_n,
   input wire logic o_fl_oe_n,
   input wire logic o_fl_we_n,
   input wire logic o_fl_reset_n,
   input wire logic o_fl_elevated,
   input wire logic o_fl_boost,
   input wire logic i_ready_busy_out
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // helper counters, saturating so that long waits cannot wrap
   logic [11:0] low_r, elev_r, rdy_r;
   logic [2:0] cmd_r;
   function automatic logic [11:0] sat(input logic on, input logic [11:0] c);
      return on ? c + {11'h000, c != 12'hFFF} : 12'h000;
   endfunction
   always @(posedge i_clock) begin
      low_r <= sat(i_rst_n && !o_fl_reset_n, low_r);
      elev_r <= sat(i_rst_n && o_fl_elevated, elev_r);
      rdy_r <= sat(i_rst_n && i_ready_busy_out, rdy_r);
      if (!i_rst_n)
         cmd_r <= 3'h0;
      else if (i_avs_write && !o_avs_waitrequest && i_avs_address == `REG_CTRL)
         cmd_r <= i_avs_writedata[2:0];
   end
   // ==========================================================
   // assertions
   sequence s_wr_low;
      (!o_fl_we_n && !o_fl_ce_n && o_fl_dq_oe) [*3];
   endsequence
   sequence s_rd_low;
      (!o_fl_oe_n && !o_fl_ce_n && !o_fl_dq_oe) [*3];
   endsequence
   a_reset_width: assert property ($rose(o_fl_reset_n) |-> low_r >= `CYC_RESET_BUSY)
      else $error("flash reset pulse short");
   a_reset_gap: assert property ($rose(o_fl_reset_n) |-> o_fl_oe_n [*5])
      else $error("read too soon after reset");
   a_write_pulse: assert property ($fell(o_fl_we_n) |-> s_wr_low ##1 o_fl_we_n)
      else $error("write pulse wrong");
   a_read_hold: assert property ($fell(o_fl_oe_n) |-> s_rd_low)
      else $error("read access cut short");
   a_prot_code: assert property (!o_fl_we_n && (cmd_r == `CMD_PROTECT || cmd_r == `CMD_UNPROTECT)
      |-> {o_fl_addr[6], o_fl_addr[1], o_fl_addr[0]} ==
      (cmd_r == `CMD_PROTECT ? `PROT_ADDR_CODE : `UNPROT_ADDR_CODE))
      else $error("protect address code wrong");
   a_elev_setup: assert property ($fell(o_fl_we_n) && o_fl_elevated |->
      elev_r >= `CYC_UNPROT_SETUP) else $error("write too soon after elevation");
   a_elev_hold: assert property ($fell(o_fl_elevated) |-> rdy_r >= `CYC_UNPROT_HOLD)
      else $error("elevation dropped too soon");
   a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
endmodule // flash_host_ctl_sva
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench: avalon master, flash model and reference array
// assumes the design's register map and command codes from its header
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defs.vh"
bind flash_host_ctl flash_host_ctl_sva flash_host_ctl_sva_inst (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_fl_addr(o_fl_addr), .i_fl_dq(i_fl_dq), .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe),
   .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n),
   .o_fl_reset_n(o_fl_reset_n), .o_fl_elevated(o_fl_elevated), .o_fl_boost(o_fl_boost),
   .i_ready_busy_out(i_ready_busy_out));
module testbench;
   logic i_clock = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
   logic [3:0] i_avs_address = 4'h0;
   logic [31:0] i_avs_writedata = 32'h0000_0000, q;
   wire [31:0] o_avs_readdata;
   wire [20:0] o_fl_addr;
   wire [15:0] i_fl_dq, o_fl_dq;
   wire o_avs_waitrequest, o_fl_dq_oe, o_fl_ce_n, o_fl_oe_n, o_fl_we_n;
   wire o_fl_reset_n, o_fl_elevated, o_fl_boost, i_ready_busy_out;
   int mismatches = 0, num_checks = 0, k, n;
   logic [15:0] mem_ref [int];
   logic [20:0] a;
   always #20 i_clock = ~i_clock;
   flash_host_ctl flash_host_ctl_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_fl_addr(o_fl_addr), .i_fl_dq(i_fl_dq),
      .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe), .o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n),
      .o_fl_we_n(o_fl_we_n), .o_fl_reset_n(o_fl_reset_n), .o_fl_elevated(o_fl_elevated),
      .o_fl_boost(o_fl_boost), .i_ready_busy_out(i_ready_busy_out));
   flash_dev_model flash_dev_model_inst (.i_ce_n(o_fl_ce_n), .i_oe_n(o_fl_oe_n),
      .i_we_n(o_fl_we_n), .i_reset_n(o_fl_reset_n), .i_boost(o_fl_boost), .i_addr(o_fl_addr),
      .i_dq_host(o_fl_dq), .i_dq_host_oe(o_fl_dq_oe), .o_dq_bus(i_fl_dq),
      .o_ready_busy_out(i_ready_busy_out));
   // ==========================================================
   // tasks
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task fail_out;
      mismatches++;
      end_sim;
   endtask
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // the request stands until waitrequest is seen low at a rising edge; data is taken there
   task bus(input logic wr, input logic [3:0] ad, input logic [31:0] dd);
      logic ok;
      ok = 1'b0;
      @(posedge i_clock);
      i_avs_address <= ad;
      i_avs_writedata <= dd;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      for (int w = 0; w < 20000 && !ok; w++) begin
         @(posedge i_clock);
         ok = (o_avs_waitrequest === 1'b0);
         q = o_avs_readdata;
      end
      if (!ok) fail_out;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task cmd(input logic [2:0] c, input logic [20:0] ad, input logic [15:0] dd,
      input logic bst, input logic elv);
      bus(1'b1, `REG_ADDR, {11'h000, ad});
      bus(1'b1, `REG_DATA, {16'h0000, dd});
      bus(1'b1, `REG_CTRL, {26'h000_0000, elv, bst, 1'b0, c});
   endtask
   task read_word(input logic [20:0] ad, input string name);
      cmd(`CMD_READ, ad, 16'h0000, 1'b0, 1'b0);
      bus(1'b0, `REG_RDATA, 32'h0000_0000);
      check(name, {16'h0000, mem_ref.exists(ad) ? mem_ref[ad] : 16'hFFFF}, q);
   endtask
   // ==========================================================
   // scenarios
   initial begin
      void'($urandom(72685));
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      bus(1'b0, `REG_STAT, 32'h0000_0000);
      check("stat idle", 32'h0000_0001, q & 32'h0000_0011);
      bus(1'b0, 4'hF, 32'h0000_0000);
      check("unmapped", 32'h0000_0000, q);
      for (k = 0; k < 3; k++) begin
         if (k != 2) a = 21'($urandom);
         mem_ref[a] = (mem_ref.exists(a) ? mem_ref[a] : 16'hFFFF) & 16'($urandom);
         cmd(`CMD_WRITE, a, mem_ref[a], k[0], 1'b0);
         bus(1'b0, `REG_STAT, 32'h0000_0000);
         check("stat busy", 32'h0000_0000, q & 32'h0000_0001);
         read_word(a ^ 21'h10_0000, "other bank");
         cmd(`CMD_POLL, {a[20], 20'($urandom)}, 16'h0000, 1'b0, 1'b0);
         cmd(`CMD_POLL, {a[20], 20'($urandom)}, 16'h0000, 1'b0, 1'b0);
         bus(1'b0, `REG_STAT, 32'h0000_0000);
         check("toggle bits", 32'h0000_0004, q & 32'h0000_000C);
         for (n = 0; n < 3000 && q[0] !== 1'b1; n++) bus(1'b0, `REG_STAT, 32'h0000_0000);
         if (n == 3000) fail_out;
         read_word(a, "read word");
      end
      a = 21'($urandom);
      cmd(`CMD_WRITE, a, 16'($urandom), 1'b0, 1'b0);
      cmd(`CMD_RESET, 21'h00_0000, 16'h0000, 1'b0, 1'b0);
      mem_ref[a] = 16'h0000;
      bus(1'b0, `REG_STAT, 32'h0000_0000);
      check("stat reset", 32'h0000_0011, q & 32'h0000_0013);
      read_word(a, "aborted word");
      for (k = 0; k < 2; k++)
         cmd(k ? `CMD_UNPROTECT : `CMD_PROTECT, 21'($urandom), 16'h0000, 1'b0, 1'b1);
      bus(1'b1, `REG_CTRL, 32'h0000_0000);
      for (n = 0; n < 2000 && o_fl_elevated !== 1'b0; n++) @(posedge i_clock);
      check("elevated off", 32'h0000_0000, {31'h0000_0000, o_fl_elevated});
      end_sim;
   end
   initial begin
      #4000000;
      fail_out;
   end
endmodule // testbench
`default_nettype wire
